// file: hw/bus_share.sv
// Purpose: Global memory request and bus release control
// Assumes: Pins already synchronous to REF_CLK except HOLD_REQ_N and READY
// Notes:   Quarter-phase counter derived internally from REF_CLK
`include "bus_share_params.svh"
module bus_share (
  input  wire logic        REF_CLK,
  input  wire logic        RST,
  input  wire logic        CORE_WR,
  input  wire logic [15:0] CORE_ADDR,
  input  wire logic [7:0]  CORE_WDATA,
  output logic      [15:0] CORE_RDATA,
  input  wire logic        DATA_ACCESS,
  input  wire logic        EXT_ACCESS,
  input  wire logic        EXT_FETCH,
  input  wire logic        INSTR_DONE,
  input  wire logic        BUS_CYCLE_DONE,
  input  wire logic        REPEAT_INSTRUCTION,
  input  wire logic        IDLE_ACTIVE,
  input  wire logic        SET_CONCURRENT_SELECT_INSTR,
  input  wire logic        CLEAR_CONCURRENT_SELECT_INSTR,
  input  wire logic        INT_REQ,
  input  wire logic        READY,
  input  wire logic        HOLD_REQ_N,
  input  wire logic        DATA_SPACE_REQ_N,
  input  wire logic        SERIAL_TX_DATA_IN,
  input  wire logic        SERIAL_TX_FRAME_SYNC_IN,
  output logic             GLOBAL_ACCESS_REQUEST_N,
  output logic             DATA_SPACE_STROBE_N,
  output logic             BUS_RELEASE_ACK_N,
  output logic             BUS_OE,
  output logic             WAIT_STATE,
  output logic             CORE_STALL,
  output logic             IDLE_RESUME,
  output logic             INT_SERVICE_EN,
  output logic             INT_PENDING,
  output logic             SERIAL_TX_DATA,
  output logic             SERIAL_TX_FRAME_SYNC,
  output logic             CONCURRENT_DMA_SELECT
);
  // --------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------
  logic hold_s1, hold_s2, ready_s1, ready_s2;
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      hold_s1  <= 1'b1;
      hold_s2  <= 1'b1;
      ready_s1 <= 1'b0;
      ready_s2 <= 1'b0;
    end else begin
      hold_s1  <= HOLD_REQ_N;
      hold_s2  <= hold_s1;
      ready_s1 <= READY;
      ready_s2 <= ready_s1;
    end
  end
  wire hold_req = !hold_s2; // Not latched: master keeps it low

  // --------------------------------------------------
  // Quarter-phase divider
  // --------------------------------------------------
  logic [1:0] quarter;
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) quarter <= 2'h0;
    else quarter <= quarter + 2'h1;
  end
  wire q3_tick    = (quarter == `QUARTER_SAMPLE); // Start of quarter three
  wire cycle_tick = (quarter == 2'h3);            // End of machine cycle

  // --------------------------------------------------
  // Window register and decode
  // --------------------------------------------------
  logic       is_global;
  logic [7:0] window;
  global_window_decode u_decode (
    .clk         (REF_CLK),
    .rst         (RST),
    .wr_en       (CORE_WR),
    .addr        (CORE_ADDR),
    .wdata       (CORE_WDATA),
    .access_addr (CORE_ADDR),
    .rdata       (CORE_RDATA),
    .is_global   (is_global),
    .window      (window)
  );

  // --------------------------------------------------
  // Concurrent select bit
  // --------------------------------------------------
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) CONCURRENT_DMA_SELECT <= 1'b0;
    else if (SET_CONCURRENT_SELECT_INSTR) CONCURRENT_DMA_SELECT <= 1'b1;
    else if (CLEAR_CONCURRENT_SELECT_INSTR) CONCURRENT_DMA_SELECT <= 1'b0;
  end

  // --------------------------------------------------
  // Release sequencer
  // --------------------------------------------------
  bus_share_pkg::rel_state_t state, next_state;
  logic [2:0] cyc_cnt, next_cyc_cnt;
  // Select set waits for whole instruction incl. repeats; clear waits for bus cycle end during a repeat, else instruction end
  wire release_ok = CONCURRENT_DMA_SELECT ? (INSTR_DONE && !REPEAT_INSTRUCTION) :
                    (REPEAT_INSTRUCTION ? BUS_CYCLE_DONE : INSTR_DONE);
  // One machine-cycle step of the float and restore countdowns
  function automatic logic [2:0] step_down(input logic [2:0] cnt);
    return cnt - 3'h1;
  endfunction
  always_comb begin
    next_state   = state;
    next_cyc_cnt = cyc_cnt;
    case (state)
      bus_share_pkg::ST_RUN: begin
        if (hold_req && q3_tick) next_state = bus_share_pkg::ST_WAIT_DONE;
      end
      bus_share_pkg::ST_WAIT_DONE: begin
        if (!hold_req) next_state = bus_share_pkg::ST_RUN;
        else if (release_ok) begin
          next_state   = bus_share_pkg::ST_FLOAT_DLY;
          next_cyc_cnt = `HOLD_FLOAT_CYCLES;
        end
      end
      bus_share_pkg::ST_FLOAT_DLY: begin
        if (cycle_tick) begin
          next_cyc_cnt = step_down(cyc_cnt);
          if (cyc_cnt == 3'h1) next_state = bus_share_pkg::ST_RELEASED;
        end
      end
      bus_share_pkg::ST_RELEASED: begin
        if (!hold_req) begin
          next_state   = bus_share_pkg::ST_RESTORE;
          next_cyc_cnt = `HOLD_VALID_CYCLES;
        end
      end
      bus_share_pkg::ST_RESTORE: begin
        if (cycle_tick) begin
          next_cyc_cnt = step_down(cyc_cnt);
          if (cyc_cnt == 3'h1) next_state = bus_share_pkg::ST_RUN;
        end
      end
      default: next_state = bus_share_pkg::ST_RUN;
    endcase
  end
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      state   <= bus_share_pkg::ST_RUN;
      cyc_cnt <= 3'h0;
    end else begin
      state   <= next_state;
      cyc_cnt <= next_cyc_cnt;
    end
  end

  wire acking   = (state == bus_share_pkg::ST_FLOAT_DLY) || (state == bus_share_pkg::ST_RELEASED);
  wire released = (state == bus_share_pkg::ST_RELEASED) || (state == bus_share_pkg::ST_RESTORE);
  // Data access that falls inside the global window
  wire global_access = DATA_ACCESS && is_global;
  // External need while buses are given away
  wire ext_need = EXT_FETCH || EXT_ACCESS || global_access;

  // --------------------------------------------------
  // Pin and core outputs
  // --------------------------------------------------
  logic wait_q;
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      GLOBAL_ACCESS_REQUEST_N <= 1'b1;
      DATA_SPACE_STROBE_N     <= 1'b1;
      BUS_RELEASE_ACK_N       <= 1'b1;
      BUS_OE                  <= 1'b1;
      wait_q                  <= 1'b0;
      CORE_STALL              <= 1'b0;
      IDLE_RESUME             <= 1'b0;
      INT_PENDING             <= 1'b0;
      SERIAL_TX_DATA          <= 1'b0;
      SERIAL_TX_FRAME_SYNC    <= 1'b0;
    end else begin
      // Request rides with the data strobe; strobe otherwise untouched
      GLOBAL_ACCESS_REQUEST_N <= !(global_access && !DATA_SPACE_REQ_N && !released);
      DATA_SPACE_STROBE_N     <= DATA_SPACE_REQ_N;
      // Ack lifts on the edge after the request is gone
      BUS_RELEASE_ACK_N       <= !(acking && hold_req);
      BUS_OE                  <= !released;
      // Ready from the arbiter ends the stretch
      wait_q                  <= global_access && !ready_s2 && !released;
      CORE_STALL              <= released && (CONCURRENT_DMA_SELECT || ext_need);
      IDLE_RESUME             <= IDLE_ACTIVE; // Idle kept across release, no vector taken
      // Set wins over the service clear
      if (released && CONCURRENT_DMA_SELECT && INT_REQ) INT_PENDING <= 1'b1;
      else if (INT_SERVICE_EN) INT_PENDING <= 1'b0;
      SERIAL_TX_DATA          <= SERIAL_TX_DATA_IN;
      SERIAL_TX_FRAME_SYNC    <= SERIAL_TX_FRAME_SYNC_IN;
    end
  end
  assign WAIT_STATE     = wait_q;
  assign INT_SERVICE_EN = !(released && CONCURRENT_DMA_SELECT);

  // --------------------------------------------------
  // Checks
  // --------------------------------------------------
  // Set instruction lands on the next edge
  AST_SEL_SET: assert property (@(posedge REF_CLK) disable iff (RST)
    SET_CONCURRENT_SELECT_INSTR |=> CONCURRENT_DMA_SELECT)
    else $error("select not set");
  // Clear instruction alone drops the select bit
  AST_SEL_CLR: assert property (@(posedge REF_CLK) disable iff (RST)
    CLEAR_CONCURRENT_SELECT_INSTR && !SET_CONCURRENT_SELECT_INSTR |=> !CONCURRENT_DMA_SELECT)
    else $error("select not cleared");
  // Three machine cycles from go-ahead to floating, only for go-ahead with quarter at 3 or 0
  AST_FLOAT_DLY: assert property (@(posedge REF_CLK) disable iff (RST)
    state == bus_share_pkg::ST_WAIT_DONE && next_state == bus_share_pkg::ST_FLOAT_DLY |=>
    ##[11:12] state == bus_share_pkg::ST_RELEASED)
    else $error("float delay wrong");
  // Buses float one edge after the released state is entered
  AST_FLOAT_OE: assert property (@(posedge REF_CLK) disable iff (RST)
    state == bus_share_pkg::ST_RELEASED |=> !BUS_OE)
    else $error("buses not floated");
  // Acknowledge only ever follows a seen request
  AST_ACK_REQ: assert property (@(posedge REF_CLK) disable iff (RST)
    !BUS_RELEASE_ACK_N |-> $past(hold_req))
    else $error("ack without request");
  // Acknowledge lifts one edge after the request is gone
  AST_ACK_DROP: assert property (@(posedge REF_CLK) disable iff (RST)
    !hold_req |=> BUS_RELEASE_ACK_N)
    else $error("ack held after request");
  // Two machine cycles of restore, whatever the phase
  AST_RESTORE: assert property (@(posedge REF_CLK) disable iff (RST)
    state == bus_share_pkg::ST_RELEASED && !hold_req |=> ##[5:8] state == bus_share_pkg::ST_RUN)
    else $error("restore length wrong");
  // Drivers return the edge after the restore count ends
  AST_OE_BACK: assert property (@(posedge REF_CLK) disable iff (RST)
    state == bus_share_pkg::ST_RESTORE && next_state == bus_share_pkg::ST_RUN |=> ##1 BUS_OE)
    else $error("buses not driven again");
  // No release while the instruction is still running, except at a bus cycle end of a repeat with select clear
  AST_WAIT_DONE: assert property (@(posedge REF_CLK) disable iff (RST)
    state == bus_share_pkg::ST_WAIT_DONE && hold_req && !release_ok |=> state == bus_share_pkg::ST_WAIT_DONE)
    else $error("released mid instruction");
  // Global request only for an address inside the window
  AST_GREQ: assert property (@(posedge REF_CLK) disable iff (RST)
    !GLOBAL_ACCESS_REQUEST_N |-> $past(is_global))
    else $error("request outside window");
  // Global request always rides with the data strobe
  AST_GREQ_STROBE: assert property (@(posedge REF_CLK) disable iff (RST)
    !GLOBAL_ACCESS_REQUEST_N |-> !DATA_SPACE_STROBE_N)
    else $error("request without strobe");
  // Wait state only while ready was still low
  AST_WAIT: assert property (@(posedge REF_CLK) disable iff (RST)
    WAIT_STATE |-> !$past(ready_s2))
    else $error("wait with ready");
  // Halting release stops the core
  AST_HALT: assert property (@(posedge REF_CLK) disable iff (RST)
    $past(released) && $past(CONCURRENT_DMA_SELECT) |-> CORE_STALL)
    else $error("not halted");
  // Concurrent release stalls as soon as the core needs the bus
  AST_STALL_NEED: assert property (@(posedge REF_CLK) disable iff (RST)
    $past(released) && $past(ext_need) |-> CORE_STALL)
    else $error("external need not stalled");
  // Service blocked while halted for a release
  AST_INT_BLOCK: assert property (@(posedge REF_CLK) disable iff (RST)
    released && CONCURRENT_DMA_SELECT |-> !INT_SERVICE_EN)
    else $error("interrupt serviced");
  // Interrupts arriving under a halting release are kept
  AST_PEND_SET: assert property (@(posedge REF_CLK) disable iff (RST)
    released && CONCURRENT_DMA_SELECT && INT_REQ |=> INT_PENDING)
    else $error("interrupt not latched");
  // Serial transmit pins pass straight through a release
  AST_SERIAL: assert property (@(posedge REF_CLK) disable iff (RST)
    SERIAL_TX_DATA == $past(SERIAL_TX_DATA_IN))
    else $error("serial disturbed");
  AST_SERIAL_FS: assert property (@(posedge REF_CLK) disable iff (RST)
    SERIAL_TX_FRAME_SYNC == $past(SERIAL_TX_FRAME_SYNC_IN))
    else $error("frame sync disturbed");
  // Idle level carried across a release, no vector taken
  AST_IDLE: assert property (@(posedge REF_CLK) disable iff (RST)
    IDLE_RESUME == $past(IDLE_ACTIVE))
    else $error("idle not kept");

  // --------------------------------------------------
  // Cover points
  // --------------------------------------------------
  COV_RELEASE: cover property (@(posedge REF_CLK) state == bus_share_pkg::ST_RELEASED);
  COV_CONCURRENT: cover property (@(posedge REF_CLK) released && !CONCURRENT_DMA_SELECT && !CORE_STALL);
  COV_GLOBAL_WAIT: cover property (@(posedge REF_CLK) WAIT_STATE ##1 !WAIT_STATE);
  COV_PENDING: cover property (@(posedge REF_CLK) INT_PENDING);
  COV_REPEAT_HOLD: cover property (@(posedge REF_CLK)
    state == bus_share_pkg::ST_WAIT_DONE && REPEAT_INSTRUCTION && BUS_CYCLE_DONE);
endmodule // bus_share

// file: hw/bus_share_params.svh
// Purpose: Constants for the global window and bus release logic
// Assumes: One machine cycle is four quarter-phases of REF_CLK
// Notes:   Included by the design files
`ifndef BUS_SHARE_PARAMS_SVH
`define BUS_SHARE_PARAMS_SVH
`define GLOBAL_WINDOW_ADDR     16'h0005
`define GLOBAL_WINDOW_RESET    8'h00
`define UPPER_READ_FILL        8'hFF
`define HOLD_FLOAT_CYCLES      3'h3
`define HOLD_VALID_CYCLES      3'h2
`define QUARTER_SAMPLE         2'h2
`endif

// file: hw/bus_share_pkg.sv
// Purpose: Types for the bus sharing block
// Assumes: Nothing beyond the params header
// Notes:   States of the release sequencer
package bus_share_pkg;
  typedef enum logic [2:0] {ST_RUN, ST_WAIT_DONE, ST_FLOAT_DLY, ST_RELEASED, ST_RESTORE} rel_state_t;
endpackage

// file: hw/global_window_decode.sv
// Purpose: Global window register and address classification
// Assumes: Register written from the internal data bus
// Notes:   Upper eight bits of the location read as ones
`include "bus_share_params.svh"
module global_window_decode (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        wr_en,
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  wdata,
  input  wire logic [15:0] access_addr,
  output logic      [15:0] rdata,
  output logic             is_global,
  output logic      [7:0]  window
);
  // --------------------------------------------------
  // Window register storage
  // --------------------------------------------------
  wire sel = (addr == `GLOBAL_WINDOW_ADDR);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      window <= `GLOBAL_WINDOW_RESET;
    end else if (wr_en && sel) begin
      window <= wdata;
    end
  end
  // Read data, upper byte has no storage
  assign rdata = {`UPPER_READ_FILL, window};
  // Mask compare; patterns 000000XX never match since bit 7 is clear
  assign is_global = window[7] && ((access_addr[15:8] & window) == window);
  // Non-listed patterns fragment the map, left to software
  AST_UPPER_ONES: assert property (@(posedge clk) disable iff (rst)
    rdata[15:8] == 8'hFF)
    else $error("upper byte not ones");
  AST_NO_GLOBAL: assert property (@(posedge clk) disable iff (rst)
    !window[7] |-> !is_global)
    else $error("global with clear top bit");
  AST_WRITE: assert property (@(posedge clk) disable iff (rst)
    wr_en && sel |=> window == $past(wdata))
    else $error("window write lost");
endmodule // global_window_decode

// file: sim/far_side_model.sv
// Purpose: Shared-memory arbiter and DMA master facing the bus sharing block
// Assumes: Both answer on REF_CLK, changing just after the rising edge
// Notes:   Grant comes late on purpose so global cycles see wait states
module far_side_model #(
  parameter int GRANT_DELAY = 5
) (
  input  wire logic clk,
  input  wire logic req_n,
  input  wire logic ack_n,
  input  wire logic want_hold,
  output logic      ready,
  output logic      hold_req_n
);
  timeunit 1ns;
  timeprecision 1ns;
  int unsigned wait_cnt = 0;
  initial ready = 1'b0;
  initial hold_req_n = 1'b1;
  // Arbiter grants after a delay; release request is kept until acknowledged
  always @(posedge clk) begin
    #1;
    wait_cnt = req_n ? 0 : wait_cnt + 1;
    ready = !req_n && (wait_cnt > GRANT_DELAY);
    hold_req_n = want_hold ? 1'b0 : (ack_n ? hold_req_n : 1'b1);
  end
endmodule // far_side_model

// file: sim/testbench.sv
// Purpose: Self-checking bench for global window and bus release
// Assumes: Expected values noted with the cycle at which they must show
// Notes:   Monitor compares on the falling edge, oldest note first
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {int cyc; int sel; logic [15:0] exp;} note_t;
  logic REF_CLK = 0, RST = 1, wr = 0, acc = 0, ext = 0, fetch = 0, done = 1, bcd = 0, rpt = 0, idle = 0;
  logic set_i = 0, clr_i = 0, irq = 0, ds_req_n = 1, tx_d = 0, tx_fs = 0, want_hold = 0;
  logic [15:0] addr = 16'h0000, a;
  logic [7:0]  wdata = 8'h00, w;
  wire  [15:0] rdata;
  wire         ready, hold_n, greq_n, ds_n, ack_n, oe, wst, stall, idle_res, svc, pend, tx_do, tx_fso, sel;
  wire  [10:0] flags = {idle_res, sel, svc, pend, tx_fso, tx_do, stall, wst, oe, ack_n, greq_n};
  note_t notes[$], n;
  int cyc = 0, num_errors = 0, samples_checked = 0;
  string names[13] = '{"rdata", "greq_n", "ack_n", "bus_oe", "wait", "stall", "tx_d", "tx_fs", "pend",
                       "svc_en", "select", "idle", "ds_n"};
  always #5 REF_CLK = ~REF_CLK;
  always @(posedge REF_CLK) cyc <= cyc + 1;
  bus_share i_bus_share (.REF_CLK(REF_CLK), .RST(RST), .CORE_WR(wr), .CORE_ADDR(addr), .CORE_WDATA(wdata),
    .CORE_RDATA(rdata), .DATA_ACCESS(acc), .EXT_ACCESS(ext), .EXT_FETCH(fetch), .INSTR_DONE(done),
    .BUS_CYCLE_DONE(bcd), .REPEAT_INSTRUCTION(rpt), .IDLE_ACTIVE(idle), .SET_CONCURRENT_SELECT_INSTR(set_i),
    .CLEAR_CONCURRENT_SELECT_INSTR(clr_i), .INT_REQ(irq), .READY(ready), .HOLD_REQ_N(hold_n),
    .DATA_SPACE_REQ_N(ds_req_n), .SERIAL_TX_DATA_IN(tx_d), .SERIAL_TX_FRAME_SYNC_IN(tx_fs),
    .GLOBAL_ACCESS_REQUEST_N(greq_n), .DATA_SPACE_STROBE_N(ds_n), .BUS_RELEASE_ACK_N(ack_n), .BUS_OE(oe),
    .WAIT_STATE(wst), .CORE_STALL(stall), .IDLE_RESUME(idle_res), .INT_SERVICE_EN(svc), .INT_PENDING(pend),
    .SERIAL_TX_DATA(tx_do), .SERIAL_TX_FRAME_SYNC(tx_fso), .CONCURRENT_DMA_SELECT(sel));
  far_side_model i_far_side_model (.clk(REF_CLK), .req_n(greq_n), .ack_n(ack_n), .want_hold(want_hold),
    .ready(ready), .hold_req_n(hold_n));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  function automatic logic [15:0] obs(int s);
    return (s == 0) ? rdata : (s == 12) ? {15'h0000, ds_n} : {15'h0000, flags[s-1]};
  endfunction
  task automatic check(int s, logic [15:0] seen, logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", names[s], exp, seen);
    end
  endtask
  task automatic tick(int k);
    repeat (k) @(posedge REF_CLK);
    #1;
  endtask
  task automatic note(int s, logic [15:0] e, int d);
    notes.push_back('{cyc + d, s, e});
  endtask
  // Bounded wait, then the expected level is noted for this cycle
  task automatic wait_for(int s, logic [15:0] e, int lim);
    for (int i = 0; i < lim && obs(s) !== e; i++) tick(1);
    note(s, e, 0);
  endtask
  task automatic wreg(logic [15:0] ad, logic [7:0] d);
    addr = ad;
    wdata = d;
    wr = 1'b1;
    tick(1);
    wr = 1'b0;
    tick(1);
  endtask
  task automatic pulse_sel(logic s);
    set_i = s;
    clr_i = !s;
    tick(1);
    {set_i, clr_i} = 2'b00;
    note(10, {15'h0000, s}, 0);
  endtask
  task automatic complete_run;
    // Notes still queued were never compared
    num_errors += notes.size();
    $display("checked %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Monitor takes due notes from the head, up to the first note not yet due
  always @(negedge REF_CLK) begin
    while (notes.size() > 0 && notes[0].cyc <= cyc) begin
      n = notes.pop_front();
      check(n.sel, obs(n.sel), n.exp);
    end
  end
  // Watchdog: run needs well under two thousand cycles
  initial begin
    #50000;
    num_errors++;
    complete_run();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h358ebad8));
    tick(4);
    RST = 1'b0;
    tick(1);
    note(0, 16'hFF00, 0);
    wreg(16'h0006, 8'hC0);
    note(0, 16'hFF00, 0);
    w = 8'($urandom);
    wreg(16'h0005, w);
    note(0, {8'hFF, w}, 0);
    $display("test register done");
    // Every legal size pattern, with region boundary and random addresses
    for (int k = 0; k < 9; k++) begin
      w = (k == 0) ? 8'h03 : 8'(8'hFF << (8 - k)); // Listed patterns only
      wreg(16'h0005, w);
      for (int j = 0; j < 3; j++) begin
        a = (j == 2) ? 16'($urandom) : {w, 8'h00} - 16'(j);
        {addr, acc, ds_req_n} = {a, 2'b10};
        // Region starts at the pattern followed by a zero byte
        note(1, {15'h0000, !(k > 0 && a >= {w, 8'h00})}, 1);
        note(12, 16'h0000, 1);
        tick(1);
        {acc, ds_req_n} = 2'b01;
        tick(2);
      end
    end
    $display("test classify done");
    wreg(16'h0005, 8'h80);
    {addr, acc, ds_req_n} = {16'h9000, 2'b10};
    wait_for(4, 16'h0001, 6);
    note(1, 16'h0000, 0);
    wait_for(4, 16'h0000, 20);
    {acc, ds_req_n} = 2'b01;
    tick(3);
    $display("test wait states done");
    // Halting release: instruction must finish first, interrupts held off
    pulse_sel(1'b1);
    // Repeat running, bus cycles ending: select set waits for the count
    {idle, done, rpt, bcd, want_hold} = 5'b10111;
    tick(30);
    note(2, 16'h0001, 0);
    {done, rpt} = 2'b10;
    wait_for(2, 16'h0000, 40);
    note(3, 16'h0001, 0);
    wait_for(3, 16'h0000, 20);
    {tx_d, tx_fs, irq} = {2'($urandom), 1'b1};
    note(5, 16'h0001, 0);
    note(9, 16'h0000, 0);
    note(6, {15'h0000, tx_d}, 1);
    note(7, {15'h0000, tx_fs}, 1);
    note(8, 16'h0001, 2);
    tick(3);
    {irq, want_hold} = 2'b00;
    wait_for(2, 16'h0001, 8);
    wait_for(3, 16'h0001, 12);
    note(11, 16'h0001, 0);
    $display("test halting release done");
    // Concurrent release: internal code runs until it needs the bus
    pulse_sel(1'b0);
    // Select clear releases at the bus cycle end of a running repeat
    {rpt, bcd, done, want_hold} = 4'b1001;
    tick(20);
    note(2, 16'h0001, 0);
    bcd = 1'b1;
    wait_for(2, 16'h0000, 40);
    {rpt, done} = 2'b01;
    wait_for(3, 16'h0000, 20);
    note(5, 16'h0000, 1);
    note(9, 16'h0001, 0);
    tick(2);
    fetch = 1'b1;
    wait_for(5, 16'h0001, 3);
    {fetch, ext} = 2'b01;
    note(5, 16'h0001, 1);
    tick(2);
    // Stall lasts until the release is over while the need is pending
    want_hold = 1'b0;
    wait_for(2, 16'h0001, 8);
    note(5, 16'h0001, 0);
    wait_for(3, 16'h0001, 12);
    note(5, 16'h0000, 0);
    ext = 1'b0;
    $display("test concurrent release done");
    tick(3);
    complete_run();
  end
endmodule // testbench
